// File: tir_defines.vh
// constants for the trigger input response block: offsets, fields, codes, reset values
// assumes an ahb-lite slave with 32-bit data and one word per register
`ifndef TIR_DEFINES_VH
`define TIR_DEFINES_VH

`define TIR_NUM_LINES      5
`define TIR_NUM_CHANS      3

// register byte offsets
`define TIR_CFG_BASE       8'h00
`define TIR_CFG_STRIDE     8'h04
`define TIR_STATUS_ADDR    8'h14

// per-line configuration word fields
`define TIR_CFG_EN_BIT     0
`define TIR_CFG_TYPE_LO    1
`define TIR_CFG_SENS_LO    4
`define TIR_CFG_CHAN_LO    6
`define TIR_CFG_RESP_LO    9
`define TIR_CFG_WIDTH      13
`define TIR_CFG_RESET      13'h0000

// status word fields
`define TIR_ST_LEVEL_LO    0
`define TIR_ST_ON_LO       5
`define TIR_ST_MODE_LO     8
`define TIR_ST_PAIR_LO     14

// detection types
`define TIR_TYPE_RISE      3'h0
`define TIR_TYPE_FALL      3'h1
`define TIR_TYPE_HIGH      3'h2
`define TIR_TYPE_LOW       3'h3
`define TIR_TYPE_STATE     3'h4

// sensitivity codes and filter lengths in consecutive samples
`define TIR_SENS_LOW       2'h0
`define TIR_SENS_MID       2'h1
`define TIR_SENS_HIGH      2'h2
`define TIR_FLT_LOW        5'h10
`define TIR_FLT_MID        5'h08
`define TIR_FLT_HIGH       5'h02

// response actions
`define TIR_RESP_ON        4'h0
`define TIR_RESP_OFF       4'h1
`define TIR_RESP_TOGGLE    4'h2
`define TIR_RESP_POWER     4'h3
`define TIR_RESP_CV        4'h4
`define TIR_RESP_CC        4'h5
`define TIR_RESP_CR        4'h6
`define TIR_RESP_IND       4'h7
`define TIR_RESP_SER       4'h8
`define TIR_RESP_PAR       4'h9

// channel operating modes and pairing modes
`define TIR_MODE_SOURCE    2'h0
`define TIR_MODE_CV        2'h1
`define TIR_MODE_CC        2'h2
`define TIR_MODE_CR        2'h3
`define TIR_PAIR_IND       2'h0
`define TIR_PAIR_SER       2'h1
`define TIR_PAIR_PAR       2'h2

// ahb codes
`define TIR_HTRANS_NONSEQ  2'h2
`define TIR_HRESP_OKAY     1'b0

`endif

// File: tir_top.v
// trigger input response: five filtered trigger lines driving channel output state
// assumes ahb-lite master, trigger inputs synchronous-ish to hclk, one clock domain
//
// Contract
// - five lines, each with readable enable
// - rise, fall, high, low or state detection
// - on response switches assigned channels on
// - off response switches assigned channels off
// - toggle inverts assigned channels each occurrence
// - power response sets assigned channels source mode
// - load responses set assigned channels load mode
// - pairing responses set channels one, two pairing
// - per-line readable three-channel assignment mask
// - low, mid, high sensitivity; low rejects most
// - per-line response action reads back
//
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "tir_defines.vh"

module tir_top (
    // clock, reset, enable
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        ce,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output wire [31:0] hrdata,
    // trigger lines
    input  wire [4:0]  trig_line_in,
    // channel control
    output wire [2:0]  chan_on,
    output wire [5:0]  chan_mode,
    output wire [1:0]  pair_mode
);

    localparam NL = `TIR_NUM_LINES;
    localparam NC = `TIR_NUM_CHANS;
    localparam CW = `TIR_CFG_WIDTH;

    // filter length for a sensitivity code; unused code behaves as high
    function [4:0] flt_len;
        input [1:0] sens;
        begin
            case (sens)
                `TIR_SENS_LOW: flt_len = `TIR_FLT_LOW;
                `TIR_SENS_MID: flt_len = `TIR_FLT_MID;
                default:       flt_len = `TIR_FLT_HIGH;
            endcase
        end
    endfunction

    // register index of a byte address, NL when not a config word
    function [2:0] cfg_index;
        input [7:0] a;
        begin
            if (a[1:0] == 2'h0 && a < (`TIR_CFG_BASE + NL * `TIR_CFG_STRIDE))
                cfg_index = a[4:2];
            else
                cfg_index = NL[2:0];
        end
    endfunction

    reg  [CW-1:0]   cfg_r [0:NL-1];
    reg  [2:0]      on_r;
    reg  [5:0]      mode_r;
    reg  [1:0]      pair_r;
    reg  [31:0]     rdata_r;
    reg             wr_pend_r;
    reg  [7:0]      wr_addr_r;
    reg  [2:0]      on_nxt;
    reg  [5:0]      mode_nxt;
    reg  [1:0]      pair_nxt;
    reg  [31:0]     rd_nxt;
    wire [NL-1:0]   filt;
    wire [NL-1:0]   fire;
    integer         i;
    integer         c;

    assign hreadyout = 1'b1;
    assign hresp     = `TIR_HRESP_OKAY;
    assign hrdata    = rdata_r;
    assign chan_on   = on_r;
    assign chan_mode = mode_r;
    assign pair_mode = pair_r;

    // per-line synchroniser, filter and detector
    genvar g;
    generate
        for (g = 0; g < NL; g = g + 1) begin : line
            reg        sync1_r;
            reg        sync2_r;
            reg        filt_r;
            reg        filt_d_r;
            reg        lvl_prev_r;
            reg  [4:0] cnt_r;
            wire       en    = cfg_r[g][`TIR_CFG_EN_BIT];
            wire [2:0] typ   = cfg_r[g][`TIR_CFG_TYPE_LO +: 3];
            wire [4:0] len   = flt_len(cfg_r[g][`TIR_CFG_SENS_LO +: 2]);
            wire       rise  = filt_r & ~filt_d_r;
            wire       fall  = ~filt_r & filt_d_r;
            wire       lvl   = en & (((typ == `TIR_TYPE_HIGH) & filt_r) |
                                     ((typ == `TIR_TYPE_LOW) & ~filt_r));
            wire       edg   = ((typ == `TIR_TYPE_RISE) & rise) |
                               ((typ == `TIR_TYPE_FALL) & fall) |
                               ((typ == `TIR_TYPE_STATE) & (rise | fall));

            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sync1_r    <= 1'b0;
                    sync2_r    <= 1'b0;
                    filt_r     <= 1'b0;
                    filt_d_r   <= 1'b0;
                    lvl_prev_r <= 1'b0;
                    cnt_r      <= 5'h00;
                end else if (ce) begin
                    sync1_r  <= trig_line_in[g];
                    sync2_r  <= sync1_r;
                    filt_d_r <= filt_r;
                    lvl_prev_r <= lvl;
                    // a change is taken only after len equal samples in a row
                    if (sync2_r == filt_r) begin
                        cnt_r <= 5'h00;
                    end else if (cnt_r + 5'h01 >= len) begin
                        filt_r <= sync2_r;
                        cnt_r  <= 5'h00;
                    end else begin
                        cnt_r <= cnt_r + 5'h01;
                    end
                end
            end

            assign filt[g] = filt_r;
            // level fires on entry only, so a held level does not re-toggle
            assign fire[g] = (en & edg) | (lvl & ~lvl_prev_r);
        end
    endgenerate

    // apply responses in line order; a higher line wins a same-cycle conflict
    always @* begin
        on_nxt   = on_r;
        mode_nxt = mode_r;
        pair_nxt = pair_r;
        for (i = 0; i < NL; i = i + 1) begin
            if (fire[i]) begin
                case (cfg_r[i][`TIR_CFG_RESP_LO +: 4])
                    `TIR_RESP_IND: pair_nxt = `TIR_PAIR_IND;
                    `TIR_RESP_SER: pair_nxt = `TIR_PAIR_SER;
                    `TIR_RESP_PAR: pair_nxt = `TIR_PAIR_PAR;
                    default: begin
                        for (c = 0; c < NC; c = c + 1) begin
                            if (cfg_r[i][`TIR_CFG_CHAN_LO + c]) begin
                                case (cfg_r[i][`TIR_CFG_RESP_LO +: 4])
                                    `TIR_RESP_ON:     on_nxt[c] = 1'b1;
                                    `TIR_RESP_OFF:    on_nxt[c] = 1'b0;
                                    `TIR_RESP_TOGGLE: on_nxt[c] = ~on_nxt[c];
                                    `TIR_RESP_POWER:  mode_nxt[2*c +: 2] = `TIR_MODE_SOURCE;
                                    `TIR_RESP_CV:     mode_nxt[2*c +: 2] = `TIR_MODE_CV;
                                    `TIR_RESP_CC:     mode_nxt[2*c +: 2] = `TIR_MODE_CC;
                                    `TIR_RESP_CR:     mode_nxt[2*c +: 2] = `TIR_MODE_CR;
                                    default:          on_nxt[c] = on_nxt[c];
                                endcase
                            end
                        end
                    end
                endcase
            end
        end
    end

    // read mux with write bypass, so a read right after a write sees new data
    always @* begin
        rd_nxt = 32'h0000_0000;
        if (cfg_index(haddr[7:0]) != NL[2:0]) begin
            if (wr_pend_r && wr_addr_r == haddr[7:0])
                rd_nxt[CW-1:0] = hwdata[CW-1:0];
            else
                rd_nxt[CW-1:0] = cfg_r[cfg_index(haddr[7:0])];
        end else if (haddr[7:0] == `TIR_STATUS_ADDR) begin
            rd_nxt[`TIR_ST_LEVEL_LO +: 5] = filt;
            rd_nxt[`TIR_ST_ON_LO +: 3]    = on_r;
            rd_nxt[`TIR_ST_MODE_LO +: 6]  = mode_r;
            rd_nxt[`TIR_ST_PAIR_LO +: 2]  = pair_r;
        end
    end

    // bus side: zero wait states, full-word access only, unmapped reads zero
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_r   <= 32'h0000_0000;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            for (i = 0; i < NL; i = i + 1)
                cfg_r[i] <= `TIR_CFG_RESET;
        end else if (ce) begin
            if (wr_pend_r && cfg_index(wr_addr_r) != NL[2:0])
                cfg_r[cfg_index(wr_addr_r)] <= hwdata[CW-1:0];
            wr_pend_r <= 1'b0;
            if (hready && hsel && htrans == `TIR_HTRANS_NONSEQ) begin
                wr_pend_r <= hwrite;
                wr_addr_r <= haddr[7:0];
                if (!hwrite)
                    rdata_r <= rd_nxt;
            end
        end
    end

    // channel state owned by trigger responses
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            on_r   <= 3'h0;
            mode_r <= 6'h00;
            pair_r <= `TIR_PAIR_IND;
        end else if (ce) begin
            on_r   <= on_nxt;
            mode_r <= mode_nxt;
            pair_r <= pair_nxt;
        end
    end

endmodule
`default_nettype wire

// File: tir_checker.sv
// checker for tir_top: bus answers, readback shape, causes of output changes
// assumes only tir_top ports, one hclk domain, hresetn async active low
`timescale 1ns/10ps
`default_nettype none
module tir_checker (
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // bus and lines
    input wire logic        ce,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic [4:0]  trig_line_in,
    // channel state
    input wire logic [2:0]  chan_on,
    input wire logic [5:0]  chan_mode,
    input wire logic [1:0]  pair_mode
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic       tk;
    logic [5:0] age_r;
    assign tk = ce && hready && hsel && htrans == 2'h2;
    // cycles since an input or config change; a response later than the filter allows is wrong
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) age_r <= 6'h00;
        else if ($changed(trig_line_in) || (tk && hwrite)) age_r <= 6'h00;
        else if (ce && age_r != 6'h3f) age_r <= age_r + 6'h01;
    end
    okay_resp_a: assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait okay");
    read_hold_a: assert property ($changed(hrdata) |-> $past(tk && !hwrite))
        else $error("read data moved without a read");
    cfg_upper_a: assert property (tk && !hwrite && haddr[7:0] < 8'h14 |=> hrdata[31:13] == 19'h0)
        else $error("config upper bits not zero");
    unmapped_zero_a: assert property (tk && !hwrite && haddr[7:0] > 8'h14 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    status_mirror_a: assert property (tk && !hwrite && haddr[7:0] == 8'h14
        |=> hrdata[15:5] == $past({pair_mode, chan_mode, chan_on}))
        else $error("status does not mirror outputs");
    ce_freeze_a: assert property (!ce |=> $stable({chan_on, chan_mode, pair_mode}))
        else $error("outputs moved with ce low");
    out_cause_a: assert property ($changed({chan_on, chan_mode, pair_mode}) |-> age_r <= 6'd24)
        else $error("output change without recent cause");
    pair_legal_a: assert property (pair_mode != 2'h3)
        else $error("illegal pairing mode");
endmodule
bind tir_top tir_checker u_tir_checker (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hreadyout, .hresp, .hrdata, .trig_line_in, .chan_on, .chan_mode, .pair_mode);
`default_nettype wire

// File: tir_trig_src.sv
// model of the equipment driving the five trigger lines
// assumes levels change just after a rising hclk edge and are held
`timescale 1ns/10ps
`default_nettype none
module tir_trig_src (
    // clock
    input  wire logic       hclk,
    // trigger lines
    output var  logic [4:0] lines
);
    initial lines = 5'h00;
    // short holds stand in for noise glitches
    task automatic drive(input int idx, input logic lvl, input int cyc);
        @(posedge hclk);
        lines[idx] <= lvl;
        repeat (cyc) @(posedge hclk);
    endtask
endmodule
`default_nettype wire

// File: tir_top_tb.sv
// self-checking bench for tir_top: register readback and trigger responses
// assumes tir_checker bound to tir_top and tir_trig_src on the lines
`timescale 1ns/10ps
`default_nettype none
`include "tir_defines.vh"
module tir_top_tb;
    logic        hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
    logic [1:0]  htrans = 2'h0, pair_mode, e_pair = 2'h0;
    logic [2:0]  hsize = 3'h2, chan_on, e_on = 3'h0;
    logic [5:0]  chan_mode, e_mode = 6'h00;
    logic [4:0]  trig;
    logic        hreadyout, hresp;
    int          errors = 0, compares = 0, cyc = 0;
    always #20 hclk = ~hclk;
    tir_top u_tir_top (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .trig_line_in(trig), .chan_on,
        .chan_mode, .pair_mode);
    tir_trig_src u_tir_trig_src (.hclk, .lines(trig));
    task automatic final_report();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic chk_out();
        chk("chan_state", {21'h0, e_pair, e_mode, e_on}, {21'h0, pair_mode, chan_mode, chan_on});
    endtask
    // single transfer; read data taken at the edge that ends the data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    function automatic logic [31:0] cw(logic e, logic [2:0] t, logic [1:0] s, logic [2:0] m,
        logic [3:0] r);
        return {19'h0, r, m, s, t, e};
    endfunction
    task automatic apply(input logic [3:0] r, input logic [2:0] m);
        for (int c = 0; c < 3; c++) if (m[c]) case (r)
            4'h0: e_on[c] = 1'b1;
            4'h1: e_on[c] = 1'b0;
            4'h2: e_on[c] = ~e_on[c];
            4'h3, 4'h4, 4'h5, 4'h6: e_mode[2*c+:2] = 2'(r - 4'h3);
            default: ;
        endcase
        if (r > 4'h6 && r < 4'ha) e_pair = 2'(r - 4'h7);
    endtask
    task automatic t_regs();
        for (int n = 0; n < 5; n++)
            bus(1, 8'(4*n), 32'hffff_e000 | cw(n[0], 3'(n+7), 2'(n%3), 3'(n+1), 4'(n+5)));
        for (int n = 0; n < 5; n++) begin
            bus(0, 8'(4*n), 0);
            chk("cfg", cw(n[0], 3'(n+7), 2'(n%3), 3'(n+1), 4'(n+5)), rd);
            bus(1, 8'(4*n), 0);
        end
        bus(1, 8'h14, 32'hffff_ffff);
        bus(0, 8'h14, 0);
        chk("status", 32'h0, rd);
        bus(0, 8'h20, 0);
        chk("unmapped", 32'h0, rd);
        $display("test regs done");
    endtask
    task automatic t_resp();
        for (int r = 9; r >= 0; r--) begin
            bus(1, 8'h00, cw(1, `TIR_TYPE_RISE, `TIR_SENS_HIGH, 3'b011, 4'(r)));
            u_tir_trig_src.drive(0, 1'b1, 10);
            apply(4'(r), 3'b011);
            chk_out();
            u_tir_trig_src.drive(0, 1'b0, 10);
            chk_out();
        end
        $display("test responses done");
    endtask
    task automatic t_trig();
        bus(1, 8'h04, cw(1, `TIR_TYPE_RISE, `TIR_SENS_LOW, 3'b100, `TIR_RESP_ON));
        bus(1, 8'h08, cw(0, `TIR_TYPE_RISE, `TIR_SENS_HIGH, 3'b011, `TIR_RESP_OFF));
        u_tir_trig_src.drive(1, 1'b1, 10);
        u_tir_trig_src.drive(1, 1'b0, 20);
        u_tir_trig_src.drive(2, 1'b1, 10);
        chk_out();
        u_tir_trig_src.drive(1, 1'b1, 24);
        e_on[2] = 1'b1;
        chk_out();
        bus(1, 8'h0c, cw(1, `TIR_TYPE_HIGH, `TIR_SENS_HIGH, 3'b100, `TIR_RESP_TOGGLE));
        bus(1, 8'h10, cw(1, `TIR_TYPE_FALL, `TIR_SENS_MID, 3'b001, `TIR_RESP_TOGGLE));
        bus(1, 8'h08, cw(1, `TIR_TYPE_STATE, `TIR_SENS_HIGH, 3'b010, `TIR_RESP_TOGGLE));
        u_tir_trig_src.drive(3, 1'b1, 30);
        e_on[2] = ~e_on[2];
        chk_out();
        u_tir_trig_src.drive(4, 1'b1, 20);
        u_tir_trig_src.drive(4, 1'b0, 20);
        e_on[0] = ~e_on[0];
        chk_out();
        u_tir_trig_src.drive(2, 1'b0, 10);
        u_tir_trig_src.drive(2, 1'b1, 10);
        chk_out();
        bus(1, 8'h0c, cw(1, `TIR_TYPE_LOW, `TIR_SENS_HIGH, 3'b100, `TIR_RESP_TOGGLE));
        @(posedge hclk) ce <= 1'b0;
        u_tir_trig_src.drive(3, 1'b0, 20);
        chk_out();
        @(posedge hclk) ce <= 1'b1;
        repeat (20) @(posedge hclk);
        e_on[2] = ~e_on[2];
        chk_out();
        // lines left at 0,1,1,0,0 after the filters settle
        bus(0, 8'h14, 0);
        chk("status_live", {16'h0, e_pair, e_mode, e_on, 5'b00110}, rd);
        $display("test trigger lines done");
    endtask
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_resp();
        t_trig();
        final_report();
    end
endmodule
`default_nettype wire
